/* logic/ccd_clutch.sv */
// Cam clutch disengage control with register port and interrupt
//
// Summary of operation
// - In the lead state each master pulse steps the remaining lead count, engaging at zero.
// - Clearing the cam enable bit returns the state machine to stop from any state.
// - A lead count driven the wrong way until it overflows clears enable and forces stop.
// - The disengage condition is looked at only while engaged.
// - Code zero never disengages; only clearing enable leaves engagement.
// - Code one goes from engaged to stop when the cam digital input drops.
// - Code two goes to stop after the signed disengage pulse count, sign giving direction.
// - Code six acts as code two but asks the slave to hold its speed while leaving.
// - Code four without the shut-down flag returns to the lead state and reloads the lead count from the re-lead count.
// - With the shut-down flag set, a disengagement clears the cam enable bit.
// - The position routine is called on disengagement only with codes two, four or six.
// - The routine start is issued in the same cycle the cam leaves the engaged state, with no delay.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "ccd_defines.svh"

module ccd_clutch #(
    parameter int CW = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input ccd_pkg::ccd_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    input ccd_pkg::ccd_master_t master,
    input wire logic cam_digital_input,
    input wire logic capture_evt,
    output logic [2:0] cam_state,
    output logic slave_follow,
    output logic speed_hold,
    output logic position_routine_start,
    output logic [7:0] position_routine_index,
    output logic irq
);
    import ccd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers and wires

    logic [31:0] cam_clutch_control_r;
    logic [CW-1:0] lead_pulse_count_r;
    logic [CW-1:0] disengage_pulse_count_r;
    logic [CW-1:0] relead_pulse_count_r;
    logic [CW-1:0] lead_rem_r;
    logic [CW-1:0] dis_rem_r;
    logic [`CCD_INT_W-1:0] int_stat_r;
    logic [`CCD_INT_W-1:0] int_mask_r;
    logic [31:0] rdata_r;
    ccd_state_t state_r;
    ccd_state_t state_nxt;
    logic slave_follow_r;
    logic speed_hold_r;
    logic pr_start_r;
    logic irq_r;

    logic wr_ctrl;
    logic cam_en;
    logic [3:0] eng_mode;
    logic [2:0] dis_sel;
    logic shut_flag;
    logic [7:0] pr_index;
    logic engage_cond;
    logic lead_step;
    logic dis_step;
    logic [CW-1:0] step_val;
    logic [CW-1:0] lead_next;
    logic [CW-1:0] dis_next;
    logic lead_ovf;
    logic lead_done;
    logic dis_cond;
    logic disengage;
    logic count_sel;
    logic to_lead_from_stop;
    logic to_engaged;
    logic relead;
    logic hw_disable;
    logic [`CCD_INT_W-1:0] int_evt;
    logic [31:0] rd_mux;

    localparam logic [CW-1:0] CNT_MAX = {1'b0, {(CW-1){1'b1}}};
    localparam logic [CW-1:0] CNT_MIN = {1'b1, {(CW-1){1'b0}}};
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};

    ////////////////////////////////////////////////////////////////////////
    // Control field decode

    assign cam_en = cam_clutch_control_r[`CCD_CTRL_EN_BIT];
    assign eng_mode = cam_clutch_control_r[`CCD_CTRL_ENG_MSB:`CCD_CTRL_ENG_LSB];
    assign dis_sel = cam_clutch_control_r[`CCD_CTRL_SEL_MSB:`CCD_CTRL_SEL_LSB];
    assign shut_flag = cam_clutch_control_r[`CCD_CTRL_SHUT_BIT];
    assign pr_index = cam_clutch_control_r[`CCD_CTRL_PR_MSB:`CCD_CTRL_PR_LSB];
    assign wr_ctrl = bus_req.wr && (bus_req.addr == `CCD_OFF_CTRL);

    ////////////////////////////////////////////////////////////////////////
    // Engage condition

    always_comb
    begin
        case (eng_mode)
            `CCD_ENG_NOW: engage_cond = 1'b1;
            `CCD_ENG_DI: engage_cond = cam_digital_input;
            `CCD_ENG_CAPTURE: engage_cond = capture_evt;
            default: engage_cond = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse counting, positive direction counts down

    assign step_val = master.dir ? ~CNT_ZERO : CNT_ONE;
    assign lead_step = (state_r == CCD_LEAD) && master.pulse;
    assign dis_step = (state_r == CCD_ENGAGED) && master.pulse;
    assign lead_next = lead_rem_r + step_val;
    assign dis_next = dis_rem_r + step_val;

    // Wrong direction runs the count away from zero until the next step would wrap it
    assign lead_ovf = lead_step && (master.dir ? (lead_rem_r == CNT_MIN)
                                               : (lead_rem_r == CNT_MAX));
    assign lead_done = (state_r == CCD_LEAD) && (lead_rem_r == CNT_ZERO);

    ////////////////////////////////////////////////////////////////////////
    // Disengage condition, only while engaged

    assign count_sel = (dis_sel == `CCD_SEL_COUNT) || (dis_sel == `CCD_SEL_CYCLE)
                       || (dis_sel == `CCD_SEL_SMOOTH);

    always_comb
    begin
        case (dis_sel)
            `CCD_SEL_NONE: dis_cond = 1'b0;
            `CCD_SEL_DI: dis_cond = !cam_digital_input;
            `CCD_SEL_COUNT: dis_cond = (dis_rem_r == CNT_ZERO);
            `CCD_SEL_SMOOTH: dis_cond = (dis_rem_r == CNT_ZERO);
            `CCD_SEL_CYCLE: dis_cond = (dis_rem_r == CNT_ZERO);
            default: dis_cond = 1'b0;
        endcase
    end

    assign disengage = cam_en && (state_r == CCD_ENGAGED) && dis_cond;
    assign relead = disengage && (dis_sel == `CCD_SEL_CYCLE);
    assign to_lead_from_stop = cam_en && (state_r == CCD_STOP) && engage_cond;
    assign to_engaged = cam_en && lead_done && !lead_ovf;
    assign hw_disable = lead_ovf || (disengage && shut_flag);

    ////////////////////////////////////////////////////////////////////////
    // State machine

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            CCD_STOP:
            begin
                if (to_lead_from_stop)
                begin
                    state_nxt = CCD_LEAD;
                end
            end
            CCD_LEAD:
            begin
                if (lead_ovf)
                begin
                    state_nxt = CCD_STOP;
                end
                else if (lead_done)
                begin
                    state_nxt = CCD_ENGAGED;
                end
            end
            CCD_ENGAGED:
            begin
                if (relead && !shut_flag)
                begin
                    state_nxt = CCD_LEAD;
                end
                else if (disengage)
                begin
                    state_nxt = CCD_STOP;
                end
            end
            default: state_nxt = CCD_STOP;
        endcase
        if (!cam_en || hw_disable)
        begin
            state_nxt = CCD_STOP;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= CCD_STOP;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Remaining lead count

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            lead_rem_r <= CW'(`CCD_CNT_RST);
        end
        else if (to_lead_from_stop)
        begin
            lead_rem_r <= lead_pulse_count_r;
        end
        else if (relead)
        begin
            lead_rem_r <= relead_pulse_count_r;
        end
        else if (lead_step && !lead_ovf && !lead_done)
        begin
            lead_rem_r <= lead_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Remaining disengage count

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            dis_rem_r <= CW'(`CCD_CNT_RST);
        end
        else if (to_engaged)
        begin
            dis_rem_r <= disengage_pulse_count_r;
        end
        else if (dis_step && (dis_rem_r != CNT_ZERO))
        begin
            dis_rem_r <= dis_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register, hardware disable beats a software write

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cam_clutch_control_r <= `CCD_CTRL_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                cam_clutch_control_r <= bus_req.wdata;
            end
            if (hw_disable)
            begin
                cam_clutch_control_r[`CCD_CTRL_EN_BIT] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count parameters

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            lead_pulse_count_r <= CW'(`CCD_CNT_RST);
            disengage_pulse_count_r <= CW'(`CCD_CNT_RST);
            relead_pulse_count_r <= CW'(`CCD_CNT_RST);
        end
        else if (bus_req.wr)
        begin
            case (bus_req.addr)
                `CCD_OFF_LEAD: lead_pulse_count_r <= bus_req.wdata[CW-1:0];
                `CCD_OFF_DISENG: disengage_pulse_count_r <= bus_req.wdata[CW-1:0];
                `CCD_OFF_RELEAD: relead_pulse_count_r <= bus_req.wdata[CW-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slave follow, speed hold and routine start outputs

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            slave_follow_r <= 1'b0;
            speed_hold_r <= 1'b0;
        end
        else
        begin
            slave_follow_r <= (state_nxt == CCD_ENGAGED);
            speed_hold_r <= disengage && (dis_sel == `CCD_SEL_SMOOTH);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pr_start_r <= 1'b0;
        end
        else
        begin
            pr_start_r <= disengage && count_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, set wins over write-one-to-clear

    assign int_evt[`CCD_INT_OVF] = lead_ovf;
    assign int_evt[`CCD_INT_DIS] = disengage;
    assign int_evt[`CCD_INT_PR] = disengage && count_sel;

    generate
        for (genvar i = 0; i < `CCD_INT_W; i++)
        begin : g_int
            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    int_stat_r[i] <= 1'b0;
                end
                else if (int_evt[i])
                begin
                    int_stat_r[i] <= 1'b1;
                end
                else if (bus_req.wr && (bus_req.addr == `CCD_OFF_INT_STAT)
                         && bus_req.wdata[i])
                begin
                    int_stat_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            int_mask_r <= `CCD_MASK_RST;
        end
        else if (bus_req.wr && (bus_req.addr == `CCD_OFF_INT_MASK))
        begin
            int_mask_r <= bus_req.wdata[`CCD_INT_W-1:0];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= |((int_stat_r | int_evt) & int_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data in the cycle after the strobe

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (bus_req.addr)
            `CCD_OFF_CTRL: rd_mux = cam_clutch_control_r;
            `CCD_OFF_LEAD: rd_mux[CW-1:0] = lead_pulse_count_r;
            `CCD_OFF_DISENG: rd_mux[CW-1:0] = disengage_pulse_count_r;
            `CCD_OFF_RELEAD: rd_mux[CW-1:0] = relead_pulse_count_r;
            `CCD_OFF_STATUS: rd_mux[2:0] = state_r;
            `CCD_OFF_LEAD_REM: rd_mux[CW-1:0] = lead_rem_r;
            `CCD_OFF_DIS_REM: rd_mux[CW-1:0] = dis_rem_r;
            `CCD_OFF_INT_STAT: rd_mux[`CCD_INT_W-1:0] = int_stat_r;
            `CCD_OFF_INT_MASK: rd_mux[`CCD_INT_W-1:0] = int_mask_r;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rdata_r <= 32'h0000_0000;
        end
        else if (bus_req.rd)
        begin
            rdata_r <= rd_mux;
        end
        else
        begin
            rdata_r <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    logic [2:0] cam_state_r;
    logic [7:0] pr_index_r;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cam_state_r <= CCD_STOP;
            pr_index_r <= 8'h00;
        end
        else
        begin
            cam_state_r <= state_nxt;
            pr_index_r <= pr_index;
        end
    end

    assign bus_rdata = rdata_r;
    assign cam_state = cam_state_r;
    assign slave_follow = slave_follow_r;
    assign speed_hold = speed_hold_r;
    assign position_routine_start = pr_start_r;
    assign position_routine_index = pr_index_r;
    assign irq = irq_r;

endmodule : ccd_clutch

/* logic/ccd_defines.svh */
// Register offsets, field positions, reset values of the cam clutch block
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH

`define CCD_ADDR_W 4
`define CCD_DATA_W 32

`define CCD_OFF_CTRL 4'h0
`define CCD_OFF_LEAD 4'h1
`define CCD_OFF_DISENG 4'h2
`define CCD_OFF_RELEAD 4'h3
`define CCD_OFF_STATUS 4'h4
`define CCD_OFF_LEAD_REM 4'h5
`define CCD_OFF_DIS_REM 4'h6
`define CCD_OFF_INT_STAT 4'h7
`define CCD_OFF_INT_MASK 4'h8

`define CCD_CTRL_EN_BIT 0
`define CCD_CTRL_ENG_LSB 4
`define CCD_CTRL_ENG_MSB 7
`define CCD_CTRL_SEL_LSB 8
`define CCD_CTRL_SEL_MSB 10
`define CCD_CTRL_SHUT_BIT 11
`define CCD_CTRL_PR_LSB 16
`define CCD_CTRL_PR_MSB 23

`define CCD_ENG_NOW 4'h0
`define CCD_ENG_DI 4'h1
`define CCD_ENG_CAPTURE 4'h2

`define CCD_SEL_NONE 3'h0
`define CCD_SEL_DI 3'h1
`define CCD_SEL_COUNT 3'h2
`define CCD_SEL_CYCLE 3'h4
`define CCD_SEL_SMOOTH 3'h6

`define CCD_INT_OVF 0
`define CCD_INT_DIS 1
`define CCD_INT_PR 2
`define CCD_INT_W 3

`define CCD_CTRL_RST 32'h0000_0000
`define CCD_CNT_RST 32'h0000_0000
`define CCD_MASK_RST 3'h0

`endif

/* logic/ccd_pkg.sv */
// Types of the cam clutch disengage block
package ccd_pkg;

    typedef enum logic [2:0] {
        CCD_STOP = 3'b001,
        CCD_LEAD = 3'b010,
        CCD_ENGAGED = 3'b100
    } ccd_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ccd_bus_req_t;

    typedef struct packed {
        logic pulse;
        logic dir;
    } ccd_master_t;

endpackage : ccd_pkg

/* verif/ccd_clutch_monitor.sv */
// Concurrent checks on the cam clutch ports
`timescale 1ns/1ps

module ccd_clutch_monitor #(
    parameter int CW = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input ccd_pkg::ccd_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    input ccd_pkg::ccd_master_t master,
    input wire logic cam_digital_input,
    input wire logic capture_evt,
    input wire logic [2:0] cam_state,
    input wire logic slave_follow,
    input wire logic speed_hold,
    input wire logic position_routine_start,
    input wire logic [7:0] position_routine_index,
    input wire logic irq
);
    import ccd_pkg::*;
    logic ctrl_wr;
    logic [2:0] sel_r;
    assign ctrl_wr = bus_req.wr && bus_req.addr == 4'h0;
    ////////////////////////////////////////////////////////////////
    // Shadow of the disengage select field
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            sel_r <= 3'h0;
        else if (ctrl_wr)
            sel_r <= bus_req.wdata[10:8];
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    a_state_onehot: assert property (cam_state inside {3'h1, 3'h2, 3'h4})
        else $error("cam state not one-hot");
    a_follow_engaged: assert property (slave_follow == (cam_state == 3'h4))
        else $error("follow level differs from engaged state");
    a_no_lead_skip: assert property ($past(cam_state) == 3'h1 |-> cam_state != 3'h4)
        else $error("engaged without lead state");
    a_start_on_leave: assert property (position_routine_start |->
        $past(cam_state) == 3'h4 && cam_state != 3'h4)
        else $error("routine start without leaving engaged");
    a_start_pulse: assert property (position_routine_start |=> !position_routine_start)
        else $error("routine start longer than one cycle");
    a_start_codes: assert property (position_routine_start |->
        sel_r inside {3'h2, 3'h4, 3'h6})
        else $error("routine start with wrong select code");
    a_hold_smooth: assert property (speed_hold |->
        position_routine_start && cam_state == 3'h1 && sel_r == 3'h6)
        else $error("speed hold outside a smooth disengage");
    a_disable_stop: assert property (ctrl_wr && !bus_req.wdata[0] |-> ##2 cam_state == 3'h1)
        else $error("no stop after enable cleared");
    a_code0_stays: assert property (!ctrl_wr && !$past(ctrl_wr) && sel_r == 3'h0
        && cam_state == 3'h4 |=> cam_state == 3'h4)
        else $error("left engaged with select code zero");
    a_di_drop: assert property (cam_state == 3'h4 && sel_r == 3'h1 && !cam_digital_input
        |-> ##[1:3] cam_state == 3'h1)
        else $error("no stop after digital input dropped");
    c_start: cover property (position_routine_start);
    c_hold: cover property (speed_hold);
    c_cycle: cover property ($past(cam_state) == 3'h4 && cam_state == 3'h2);
endmodule : ccd_clutch_monitor

bind ccd_clutch ccd_clutch_monitor #(.CW(CW)) u_ccd_clutch_monitor (.mclk(mclk), .rst(rst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .master(master),
    .cam_digital_input(cam_digital_input), .capture_evt(capture_evt), .cam_state(cam_state),
    .slave_follow(slave_follow), .speed_hold(speed_hold),
    .position_routine_start(position_routine_start),
    .position_routine_index(position_routine_index), .irq(irq));

/* verif/ccd_master_model.sv */
// Master axis pulse source and cam digital input
`timescale 1ns/1ps

module ccd_master_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic go,
    input wire logic [15:0] count,
    input wire logic dir,
    input wire logic slow,
    input wire logic di_level,
    output ccd_pkg::ccd_master_t master,
    output logic busy,
    output logic cam_digital_input
);
    import ccd_pkg::*;
    logic [15:0] left_r;
    logic gap_r;
    ////////////////////////////////////////////////////////////////
    // Pulse train, every cycle or every other cycle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            left_r <= 16'h0;
            gap_r <= 1'b0;
            master <= '0;
        end
        else
        begin
            master.dir <= dir;
            master.pulse <= !go && left_r != 16'h0 && !gap_r;
            gap_r <= slow && !gap_r && !go && left_r != 16'h0;
            if (go)
                left_r <= count;
            else if (left_r != 16'h0 && !gap_r)
                left_r <= left_r - 16'h1;
        end
    end
    assign busy = go || left_r != 16'h0 || master.pulse;
    ////////////////////////////////////////////////////////////////
    // Digital input level
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cam_digital_input <= 1'b0;
        else
            cam_digital_input <= di_level;
    end
endmodule : ccd_master_model

/* verif/ccd_clutch_tb.sv */
// Self-checking bench for the cam clutch disengage block
`timescale 1ns/1ps
`include "ccd_defines.svh"

module ccd_clutch_tb;
    import ccd_pkg::*;
    logic mclk, rst, go, dir, slow, di_level, capture_evt, busy, cam_digital_input;
    logic slave_follow, speed_hold, position_routine_start, irq;
    ccd_bus_req_t bus_req;
    ccd_master_t master;
    logic [31:0] bus_rdata, rv;
    logic [15:0] count;
    logic [2:0] cam_state;
    logic [7:0] position_routine_index;
    int err_count, check_count, starts, holds, s0, h0;

    ccd_clutch u_ccd_clutch (.mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .master(master), .cam_digital_input(cam_digital_input), .capture_evt(capture_evt),
        .cam_state(cam_state), .slave_follow(slave_follow), .speed_hold(speed_hold),
        .position_routine_start(position_routine_start),
        .position_routine_index(position_routine_index), .irq(irq));
    ccd_master_model u_ccd_master_model (.mclk(mclk), .rst(rst), .go(go), .count(count),
        .dir(dir), .slow(slow), .di_level(di_level), .master(master), .busy(busy),
        .cam_digital_input(cam_digital_input));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        starts <= starts + position_routine_start;
        holds <= holds + speed_hold;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_st(input logic [2:0] st);
        for (int i = 0; i < 12 && cam_state !== st; i++)
        begin
            @(posedge mclk);
            #1;
        end
        chk(cam_state, st);
    endtask : wait_st
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1;
        chk(bus_rdata & m, e);
    endtask : rd_chk
    task automatic pulses(input logic [15:0] n, input logic d);
        @(posedge mclk);
        go <= 1'b1;
        count <= n;
        dir <= d;
        @(posedge mclk);
        go <= 1'b0;
        #1;
        for (int i = 0; i < 100 && busy; i++)
        begin
            @(posedge mclk);
            #1;
        end
    endtask : pulses
    task automatic engage(input logic [31:0] c, input logic [15:0] l, input logic [31:0] d);
        wr(`CCD_OFF_CTRL, 32'h0);
        wr(`CCD_OFF_INT_STAT, 32'h7);
        wr(`CCD_OFF_LEAD, {16'h0, l});
        wr(`CCD_OFF_DISENG, d);
        wr(`CCD_OFF_CTRL, c);
        pulses(l, 1'b1);
        wait_st(CCD_ENGAGED);
        rd_chk(`CCD_OFF_DIS_REM, 32'hffff_ffff, d);
        s0 = starts;
        h0 = holds;
    endtask : engage
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        wait_st(CCD_STOP);
        rd_chk(`CCD_OFF_CTRL, 32'hffff_ffff, `CCD_CTRL_RST);
        rd_chk(`CCD_OFF_INT_MASK, 32'h7, 32'h0);
        rd_chk(`CCD_OFF_STATUS, 32'h7, 32'h1);
        wr(4'hf, 32'h5a5a_5a5a);
        rd_chk(4'hf, 32'hffff_ffff, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_code0;
        engage(32'h0000_0001, 16'h0, 32'h0);
        pulses(16'd20, 1'b1);
        wait_st(CCD_ENGAGED);
        wr(`CCD_OFF_CTRL, 32'h0);
        wait_st(CCD_STOP);
        wr(`CCD_OFF_CTRL, 32'h0000_0021);
        repeat (3) @(posedge mclk);
        #1;
        wait_st(CCD_STOP);
        @(posedge mclk);
        capture_evt <= 1'b1;
        @(posedge mclk);
        capture_evt <= 1'b0;
        wait_st(CCD_ENGAGED);
        wr(`CCD_OFF_CTRL, 32'h0);
        wait_st(CCD_STOP);
        $display("code0 test done");
    endtask : t_code0
    task automatic t_count(input logic [31:0] c, input int h, input logic [31:0] d);
        engage(c, 16'h1, d);
        pulses(16'h1, !d[31]);
        repeat (3) @(posedge mclk);
        #1;
        wait_st(CCD_ENGAGED);
        pulses(16'h1, !d[31]);
        wait_st(CCD_STOP);
        @(posedge mclk);
        #1;
        chk(starts - s0, 1);
        chk(holds - h0, h);
        chk(position_routine_index, c[23:16]);
        rd_chk(`CCD_OFF_CTRL, 32'h1, {31'h0, !c[11]});
        rd_chk(`CCD_OFF_INT_STAT, 32'h6, 32'h6);
        $display("count test %h done", c);
    endtask : t_count
    task automatic t_code4;
        wr(`CCD_OFF_RELEAD, 32'h3);
        engage(32'h0055_0401, 16'h1, 32'h2);
        pulses(16'h2, 1'b1);
        wait_st(CCD_LEAD);
        rd_chk(`CCD_OFF_LEAD_REM, 32'hffff_ffff, 32'h3);
        chk(starts - s0, 1);
        slow <= 1'b1;
        pulses(16'h3, 1'b1);
        slow <= 1'b0;
        wait_st(CCD_ENGAGED);
        $display("code4 test done");
    endtask : t_code4
    task automatic t_code1;
        wr(`CCD_OFF_CTRL, 32'h0);
        wr(`CCD_OFF_LEAD, 32'h2);
        wr(`CCD_OFF_CTRL, 32'h0000_0111);
        repeat (3) @(posedge mclk);
        #1;
        wait_st(CCD_STOP);
        s0 = starts;
        @(posedge mclk);
        di_level <= 1'b1;
        wait_st(CCD_LEAD);
        pulses(16'h2, 1'b1);
        wait_st(CCD_ENGAGED);
        @(posedge mclk);
        di_level <= 1'b0;
        wait_st(CCD_STOP);
        @(posedge mclk);
        #1;
        chk(starts - s0, 0);
        $display("code1 test done");
    endtask : t_code1
    task automatic t_ovf;
        wr(`CCD_OFF_CTRL, 32'h0);
        wr(`CCD_OFF_INT_STAT, 32'h7);
        wr(`CCD_OFF_INT_MASK, 32'h1);
        wr(`CCD_OFF_LEAD, 32'h7fff_ffff);
        wr(`CCD_OFF_CTRL, 32'h0000_0201);
        pulses(16'h1, 1'b0);
        wait_st(CCD_STOP);
        rd_chk(`CCD_OFF_CTRL, 32'h1, 32'h0);
        rd_chk(`CCD_OFF_INT_STAT, 32'h1, 32'h1);
        chk(irq, 1);
        wr(`CCD_OFF_INT_MASK, 32'h0);
        repeat (2) @(posedge mclk);
        #1;
        chk(irq, 0);
        wr(`CCD_OFF_INT_MASK, 32'h1);
        wr(`CCD_OFF_INT_STAT, 32'h1);
        repeat (2) @(posedge mclk);
        #1;
        chk(irq, 0);
        rd_chk(`CCD_OFF_INT_STAT, 32'h7, 32'h0);
        $display("overflow test done");
    endtask : t_ovf
    task automatic test_done;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////
    initial
    begin
        #1000000;
        err_count++;
        test_done();
    end
    initial
    begin
        rst = 1'b1;
        go = 1'b0;
        dir = 1'b1;
        slow = 1'b0;
        di_level = 1'b0;
        capture_evt = 1'b0;
        count = 16'h0;
        bus_req = '0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_code0();
        t_count(32'h00ab_0201, 0, 32'h2);
        t_count(32'h00ab_0601, 1, 32'h2);
        t_count(32'h00cd_0a01, 0, 32'hffff_fffe);
        t_code4();
        t_code1();
        t_ovf();
        test_done();
    end
endmodule : ccd_clutch_tb
